// ---- gate_drive_ctrl.sv ----
// Purpose: Drives three half bridge command pairs and watches the fault line
// Assumes: Fault line has external pull-up; inputs synchronous to CLK_IN
// Notes:   Fault line is open drain: output enable low means driving low
`include "gate_drive_defines.svh"
// Summary of operation
// R1: Separate high and low command per phase
// R2: Commands active high, low from reset
// R3: Insert dead time between phase commands
// R4: Every command pulse at least minimum width; a drop of enable_all cuts a pulse short
// R5: Carrier frequency at most twenty kilohertz
// R6: Command outputs always actively driven
// R7: Fault line read and driven both
// R8: Only pull fault line low, never drive
// R9: Device pulls line low on protections
// R10: Device holds switches off while low
// R11: Device releases line when healthy
// R12: Device holds line low after overcurrent
// R13: Drop all commands within worst hold time
// R14: Controller may force shutdown via line
// R15: Shutdown low and high at least 3 us
// R16: Device resumes switching after hold
// R17: Device gates high side on floating undervoltage
// R18: Synchronise fault line, latch sticky fault
// R19: Never assert both commands of a phase
module gate_drive_ctrl #(
	parameter int unsigned PERIOD_CYC = `MIN_CARRIER_CYC
) (
	input  wire logic                    CLK_IN,
	input  wire logic                    RST_N_IN,
	input  wire logic                    RUN_IN,
	input  wire logic [3*`DUTY_W-1:0]    DUTY_IN,
	input  wire logic                    SHUTDOWN_REQ_IN,
	input  wire logic                    FAULT_CLEAR_IN,
	input  wire logic                    FAULT_LINE_IN,
	output logic      [2:0]              HIGH_CMD_OUT,
	output logic      [2:0]              LOW_CMD_OUT,
	output logic                         FAULT_LINE_OUT,
	output logic                         FAULT_LINE_OE_N_OUT,
	output logic                         FAULT_STICKY_OUT,
	output logic                         RUNNING_OUT
);
	logic                rst_meta_q;
	logic                rst_n_q;
	logic                fault_meta_q;
	logic                fault_sync_q;
	logic                sticky_q;
	logic                sticky_d;
	logic [`CNT_W-1:0]   car_cnt_q;
	logic [`CNT_W-1:0]   car_cnt_d;
	logic                tick;
	logic                shdn_q;
	logic                shdn_d;
	logic [`CNT_W-1:0]   shdn_cnt_q;
	logic                shdn_min_met;
	logic                enable_all;
	logic [2:0]          high_w;
	logic [2:0]          low_w;
	logic [`CNT_W-1:0]   low_seen_q;
	logic                oe_prev_q;
	logic [`CNT_W-1:0]   oe_len_q;

	function automatic logic [`DUTY_W-1:0] duty_of(input logic [3*`DUTY_W-1:0] v,
		input int unsigned i);
		duty_of = v[i*`DUTY_W +: `DUTY_W];
	endfunction

	// Reset release through two flops
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// Fault line sampled through two flops
	always_ff @(posedge CLK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			fault_meta_q <= 1'b1;
			fault_sync_q <= 1'b1;
		end else begin
			fault_meta_q <= FAULT_LINE_IN; // R18
			fault_sync_q <= fault_meta_q;
		end
	end

	// Sticky fault: set wins over clear
	assign sticky_d = !fault_sync_q || (sticky_q && !FAULT_CLEAR_IN); // R18
	always_ff @(posedge CLK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sticky_q <= 1'b0;
		end else begin
			sticky_q <= sticky_d;
		end
	end

	// Carrier period counter, PERIOD_CYC cycles, at the frequency limit by default
	assign tick      = (car_cnt_q == `CNT_W'(PERIOD_CYC - 1));
	assign car_cnt_d = tick ? '0 : car_cnt_q + `CNT_W'(1);
	always_ff @(posedge CLK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			car_cnt_q <= '0;
		end else begin
			car_cnt_q <= car_cnt_d; // R5
		end
	end

	// Forced shutdown: hold low and high each for minimum width
	assign shdn_min_met = shdn_cnt_q >= `CNT_W'(`SHDN_MIN_CYC - 1);
	assign shdn_d       = shdn_min_met ? SHUTDOWN_REQ_IN : shdn_q; // R15
	always_ff @(posedge CLK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			shdn_q     <= 1'b0;
			shdn_cnt_q <= `CNT_W'(`SHDN_MIN_CYC);
		end else begin
			shdn_q     <= shdn_d;
			shdn_cnt_q <= (shdn_d != shdn_q) ? '0 :
				(shdn_min_met ? shdn_cnt_q : shdn_cnt_q + `CNT_W'(1));
		end
	end

	// Commands stop as soon as a fault is seen or forced
	assign enable_all = RUN_IN && !sticky_d && fault_sync_q && !shdn_q; // R13

	for (genvar p = 0; p < `NUM_PHASES; p++) begin : g_phase
		phase_if pif ();
		assign pif.enable = enable_all;
		assign pif.duty   = duty_of(DUTY_IN, p);
		assign pif.tick   = tick;
		assign high_w[p]  = pif.high_cmd;
		assign low_w[p]   = pif.low_cmd;
		phase_gen i_phase_gen (
			.clk   (CLK_IN),
			.rst_n (rst_n_q),
			.pif   (pif.phase)
		);
	end

	// Outputs straight from flops, always driven
	always_ff @(posedge CLK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			HIGH_CMD_OUT        <= 3'h0; // R2
			LOW_CMD_OUT         <= 3'h0; // R6
			FAULT_LINE_OUT      <= 1'b0;
			FAULT_LINE_OE_N_OUT <= 1'b1;
			FAULT_STICKY_OUT    <= 1'b0;
			RUNNING_OUT         <= 1'b0;
		end else begin
			HIGH_CMD_OUT        <= high_w & {3{enable_all}}; // R1
			LOW_CMD_OUT         <= low_w & {3{enable_all}}; // R13
			FAULT_LINE_OUT      <= 1'b0; // R8
			FAULT_LINE_OE_N_OUT <= !shdn_d; // R14
			FAULT_STICKY_OUT    <= sticky_d;
			RUNNING_OUT         <= enable_all;
		end
	end

	// Helper: cycles since the synchronised fault went low
	always_ff @(posedge CLK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			low_seen_q <= '0;
		end else if (fault_sync_q) begin
			low_seen_q <= '0;
		end else if (low_seen_q != {`CNT_W{1'b1}}) begin
			low_seen_q <= low_seen_q + `CNT_W'(1);
		end
	end

	chk_fault_cmds_low: assert property ( // R13
		@(posedge CLK_IN) disable iff (!rst_n_q)
		$fell(fault_sync_q) |-> ##[1:2] (HIGH_CMD_OUT == 3'h0 && LOW_CMD_OUT == 3'h0))
		else $error("Commands not dropped after fault");
	chk_hold_bound: assert property ( // R13
		@(posedge CLK_IN) disable iff (!rst_n_q)
		(low_seen_q >= `CNT_W'(`HOLD_WORST_CYC - 4)) |-> (HIGH_CMD_OUT | LOW_CMD_OUT) == 3'h0)
		else $error("Commands still active late in hold time");
	chk_sticky_set: assert property ( // R18
		@(posedge CLK_IN) disable iff (!rst_n_q)
		!fault_sync_q |=> FAULT_STICKY_OUT)
		else $error("Sticky fault not latched");
	chk_sticky_hold: assert property ( // R18
		@(posedge CLK_IN) disable iff (!rst_n_q)
		(FAULT_STICKY_OUT && fault_sync_q && !FAULT_CLEAR_IN) |=> FAULT_STICKY_OUT)
		else $error("Sticky fault lost without clear");
	chk_line_drive_low: assert property ( // R8
		@(posedge CLK_IN) disable iff (!rst_n_q)
		!FAULT_LINE_OE_N_OUT |-> !FAULT_LINE_OUT)
		else $error("Fault line driven high");
	chk_shdn_width: assert property ( // R15
		@(posedge CLK_IN) disable iff (!rst_n_q)
		$fell(FAULT_LINE_OE_N_OUT) |-> !FAULT_LINE_OE_N_OUT [*8] ##0
		(!FAULT_LINE_OE_N_OUT [*8]))
		else $error("Forced shutdown pulse too short");
	chk_pair_exclusive: assert property ( // R19
		@(posedge CLK_IN) disable iff (!rst_n_q)
		(HIGH_CMD_OUT & LOW_CMD_OUT) == 3'h0)
		else $error("Phase pair both high");
	chk_shdn_blocks: assert property ( // R14
		@(posedge CLK_IN) disable iff (!rst_n_q)
		!FAULT_LINE_OE_N_OUT |=> (HIGH_CMD_OUT | LOW_CMD_OUT) == 3'h0)
		else $error("Commands active during forced shutdown");

	// Helper: cycles the line enable has kept its level
	always_ff @(posedge CLK_IN or negedge rst_n_q) begin
		if (!rst_n_q) begin
			oe_prev_q <= 1'b1;
			oe_len_q  <= `CNT_W'(`SHDN_MIN_CYC);
		end else begin
			oe_prev_q <= FAULT_LINE_OE_N_OUT;
			if (oe_prev_q != FAULT_LINE_OE_N_OUT) begin
				oe_len_q <= '0;
			end else if (oe_len_q != {`CNT_W{1'b1}}) begin
				oe_len_q <= oe_len_q + `CNT_W'(1);
			end
		end
	end

	chk_shdn_level_span: assert property ( // R15
		@(posedge CLK_IN) disable iff (!rst_n_q)
		(oe_prev_q != FAULT_LINE_OE_N_OUT) |-> oe_len_q >= `CNT_W'(`SHDN_MIN_CYC - 1))
		else $error("Line enable level shorter than minimum");
	chk_fault_stops_run: assert property ( // R13
		@(posedge CLK_IN) disable iff (!rst_n_q)
		!fault_sync_q |=> !RUNNING_OUT)
		else $error("Still running while fault line low");
endmodule

// ---- gate_drive_defines.svh ----
// Purpose: Timing constants for the three-phase gate drive controller
// Assumes: 50 MHz system clock, 20 ns period
// Notes:   Times kept in ns; cycle counts derived from them
`ifndef GATE_DRIVE_DEFINES_SVH
`define GATE_DRIVE_DEFINES_SVH

`define CLK_PERIOD_NS      20
// Least times round up, longest times round down
`define DEAD_TIME_NS       1500
`define DEAD_CYC           ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_PULSE_NS       500
`define MIN_PULSE_CYC      ((`MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_CARRIER_NS     50000
`define MIN_CARRIER_CYC    ((`MIN_CARRIER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_WORST_NS      15000
`define HOLD_WORST_CYC     (`HOLD_WORST_NS / `CLK_PERIOD_NS)
`define SHDN_MIN_NS        3000
`define SHDN_MIN_CYC       ((`SHDN_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W              12
`define DUTY_W             12
`define NUM_PHASES         3

`endif

// ---- gate_drive_pkg.sv ----
// Purpose: Shared types for the gate drive controller
// Assumes: Nothing beyond the defines header
// Notes:   Phase state walks off, dead, high on, dead, low on, dead
package gate_drive_pkg;
	typedef enum logic [2:0] {
		PH_OFF,
		PH_HIGH,
		PH_DEAD_HL,
		PH_LOW,
		PH_DEAD_LH
	} phase_state_e;
endpackage

// ---- phase_if.sv ----
// Purpose: Links the top controller with one phase generator
// Assumes: Same clock domain on both sides
// Notes:   Top drives controls, phase returns pin levels
`include "gate_drive_defines.svh"
interface phase_if;
	logic                   enable;
	logic [`DUTY_W-1:0]     duty;
	logic                   tick;
	logic                   high_cmd;
	logic                   low_cmd;
	modport ctrl  (output enable, output duty, output tick, input high_cmd, input low_cmd);
	modport phase (input enable, input duty, input tick, output high_cmd, output low_cmd);
endinterface

// ---- phase_gen.sv ----
// Purpose: One phase of complementary PWM with dead time and pulse limits
// Assumes: Tick marks carrier period start
// Notes:   Both commands low in every state but PH_HIGH and PH_LOW
`include "gate_drive_defines.svh"
module phase_gen (
	input  wire logic   clk,
	input  wire logic   rst_n,
	phase_if.phase      pif
);
	gate_drive_pkg::phase_state_e state_q;
	gate_drive_pkg::phase_state_e state_d;
	logic [`CNT_W-1:0]            cnt_q;
	logic [`CNT_W-1:0]            cnt_d;
	logic [`CNT_W:0]              pos_next;
	logic                         want_high;
	logic                         timer_done;
	logic                         dead_done;
	logic                         dead_ok_q;

	// High demanded until duty cycles have passed in this state
	assign pos_next   = {1'b0, cnt_q} + {{`CNT_W{1'b0}}, 1'b1};
	assign want_high  = pif.enable && (pos_next < {1'b0, pif.duty});
	assign timer_done = cnt_q >= `CNT_W'(`MIN_PULSE_CYC - 1);
	assign dead_done  = cnt_q >= `CNT_W'(`DEAD_CYC - 1);

	always_comb begin
		state_d = state_q;
		cnt_d   = (cnt_q == {`CNT_W{1'b1}}) ? cnt_q : cnt_q + `CNT_W'(1);
		case (state_q)
			gate_drive_pkg::PH_OFF: begin
				if (pif.enable && pif.tick) begin
					state_d = gate_drive_pkg::PH_DEAD_LH;
					cnt_d   = '0;
				end
			end
			gate_drive_pkg::PH_HIGH: begin
				if (!pif.enable) begin
					state_d = gate_drive_pkg::PH_OFF;
				end else if (timer_done && !want_high) begin
					state_d = gate_drive_pkg::PH_DEAD_HL; // R4
					cnt_d   = '0;
				end
			end
			gate_drive_pkg::PH_DEAD_HL: begin
				if (!pif.enable) begin
					state_d = gate_drive_pkg::PH_OFF;
				end else if (dead_done) begin
					state_d = gate_drive_pkg::PH_LOW; // R3
					cnt_d   = '0;
				end
			end
			gate_drive_pkg::PH_LOW: begin
				if (!pif.enable) begin
					state_d = gate_drive_pkg::PH_OFF;
				end else if (timer_done && pif.tick) begin
					state_d = gate_drive_pkg::PH_DEAD_LH; // R4
					cnt_d   = '0;
				end
			end
			gate_drive_pkg::PH_DEAD_LH: begin
				if (!pif.enable) begin
					state_d = gate_drive_pkg::PH_OFF;
				end else if (dead_done) begin
					state_d = gate_drive_pkg::PH_HIGH; // R3
					cnt_d   = '0;
				end
			end
			default: begin
				state_d = gate_drive_pkg::PH_OFF;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= gate_drive_pkg::PH_OFF;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// Commands registered, never both high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pif.high_cmd <= 1'b0;
			pif.low_cmd  <= 1'b0;
		end else begin
			pif.high_cmd <= (state_d == gate_drive_pkg::PH_HIGH); // R1
			pif.low_cmd  <= (state_d == gate_drive_pkg::PH_LOW); // R19
		end
	end

	// Helper: low then high needs full dead gap
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dead_ok_q <= 1'b1;
		end else begin
			dead_ok_q <= !pif.low_cmd;
		end
	end

	chk_no_shoot_through: assert property ( // R19
		@(posedge clk) disable iff (!rst_n) !(pif.high_cmd && pif.low_cmd))
		else $error("Both commands of a phase high");
	chk_dead_gap_lh: assert property ( // R3
		@(posedge clk) disable iff (!rst_n)
		$fell(pif.low_cmd) |-> !pif.high_cmd [*8])
		else $error("High command within dead time after low");
	chk_dead_gap_hl: assert property ( // R3
		@(posedge clk) disable iff (!rst_n)
		$fell(pif.high_cmd) |-> !pif.low_cmd [*8])
		else $error("Low command within dead time after high");
	chk_high_pulse_min: assert property ( // R4
		@(posedge clk) disable iff (!rst_n)
		($rose(pif.high_cmd) && pif.enable) |-> (pif.high_cmd || !pif.enable) [*8])
		else $error("High pulse shorter than minimum");
endmodule

// ---- drive_device_model.sv ----
// Purpose: Behavioural half-bridge driver as seen at its logic pins
// Assumes: Clock times the overcurrent hold and the high-side rearm
// Notes:   Fault line resolved by the bench with a pull-up
module drive_device_model #(
	parameter int HOLD_CYC = 1300
) (
	input  wire logic       clk,
	input  wire logic [2:0] high_cmd,
	input  wire logic [2:0] low_cmd,
	input  wire logic       fault_line,
	input  wire logic       oc_sense,
	input  wire logic       logic_uv,
	input  wire logic       thermal,
	input  wire logic [2:0] float_uv,
	output logic            pull_low,
	output logic [2:0]      high_gate,
	output logic [2:0]      low_gate
);
	timeunit 1ns;
	timeprecision 1ps;
	int         hold   = 0;
	logic [2:0] h;
	logic [2:0] l;
	logic [2:0] prev_h = 3'h0;
	logic [2:0] armed  = 3'h7;
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			h[p] = (high_cmd[p] === 1'b1);
			l[p] = (low_cmd[p] === 1'b1);
		end
	end
	always @(posedge clk) begin
		hold <= oc_sense ? HOLD_CYC : (hold > 0 ? hold - 1 : 0);
		prev_h <= h;
		armed <= (armed | (h & ~prev_h)) & ~float_uv;
	end
	// Every protection except floating undervoltage pulls the shared line low
	assign pull_low = oc_sense || hold > 0 || logic_uv || thermal || |(h & l);
	assign high_gate = fault_line ? h & armed & ~float_uv : 3'h0;
	assign low_gate = fault_line ? l : 3'h0;
endmodule

// ---- test_three_phase_gate_drive_control.sv ----
// Purpose: Self-checking bench for the gate drive controller
// Assumes: Inputs change on the falling clock edge
// Notes:   Shortened carrier period for simulation
`include "gate_drive_defines.svh"
module test_three_phase_gate_drive_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER = 400;
	logic        CLK_IN = 0, RST_N_IN = 0, RUN_IN = 0, SHUTDOWN_REQ_IN = 0, FAULT_CLEAR_IN = 0;
	logic [35:0] DUTY_IN = 36'h0;
	logic [2:0]  HIGH_CMD_OUT, LOW_CMD_OUT, high_gate, low_gate;
	logic        FAULT_LINE_OUT, FAULT_LINE_OE_N_OUT, FAULT_STICKY_OUT, RUNNING_OUT, pull_low;
	logic        oc_sense = 0, logic_uv = 0, thermal = 0;
	int          err_count = 0, compares = 0;
	// Open-drain line with pull-up
	wire         line = !((FAULT_LINE_OE_N_OUT === 1'b0 && FAULT_LINE_OUT === 1'b0) || pull_low);

	gate_drive_ctrl #(.PERIOD_CYC(PER)) i_gate_drive_ctrl (.CLK_IN, .RST_N_IN, .RUN_IN, .DUTY_IN,
		.SHUTDOWN_REQ_IN, .FAULT_CLEAR_IN, .FAULT_LINE_IN(line), .HIGH_CMD_OUT, .LOW_CMD_OUT,
		.FAULT_LINE_OUT, .FAULT_LINE_OE_N_OUT, .FAULT_STICKY_OUT, .RUNNING_OUT);
	drive_device_model i_drive_device_model (.clk(CLK_IN), .high_cmd(HIGH_CMD_OUT),
		.low_cmd(LOW_CMD_OUT), .fault_line(line), .oc_sense(oc_sense), .logic_uv(logic_uv),
		.thermal(thermal), .float_uv(3'h0), .pull_low(pull_low), .high_gate(high_gate),
		.low_gate(low_gate));

	initial begin
		forever #10 CLK_IN = ~CLK_IN;
	end

	task automatic chk_bit(string name, logic exp, logic got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask

	function automatic logic sig(int k);
		case (k)
			0: return FAULT_STICKY_OUT;
			1: return line;
			2: return FAULT_LINE_OE_N_OUT;
			default: return RUNNING_OUT;
		endcase
	endfunction

	task automatic wait_sig(string name, int k, logic v, int lim, output int n);
		n = 0;
		while (sig(k) !== v && n < lim) begin
			@(negedge CLK_IN);
			n++;
		end
		chk_bit(name, v, sig(k));
	endtask

	task automatic clear_sticky();
		int n;
		// Let the high line pass the two sync flops first
		repeat (3) @(negedge CLK_IN);
		FAULT_CLEAR_IN = 1;
		@(negedge CLK_IN);
		FAULT_CLEAR_IN = 0;
		wait_sig("sticky clear", 0, 1'b0, 10, n);
	endtask

	task automatic stop_run();
		RUN_IN = 0;
		repeat (3) @(negedge CLK_IN);
		chk_bit("cmds off", 1'b0, |{HIGH_CMD_OUT, LOW_CMD_OUT});
		chk_bit("running off", 1'b0, RUNNING_OUT);
	endtask

	task automatic t_reset();
		chk_bit("cmds low", 1'b0, |{HIGH_CMD_OUT, LOW_CMD_OUT});
		chk_bit("released", 1'b1, FAULT_LINE_OE_N_OUT);
		chk_bit("sticky", 1'b0, FAULT_STICKY_OUT);
		$display("Test reset done");
	endtask

	task automatic t_pwm(int d, int exp_hi);
		int   hw[3], lw[3], gap[3], rise[3];
		int   n_both, n_dead, n_per, n_hi, n_lo, n_rise;
		logic hi, lo;
		n_both = 0; n_dead = 0; n_per = 0; n_hi = 0; n_lo = 0; n_rise = 0;
		for (int p = 0; p < 3; p++) begin
			hw[p] = 0; lw[p] = 0; gap[p] = 1000; rise[p] = -1;
		end
		DUTY_IN = {3{d[11:0]}};
		RUN_IN = 1;
		for (int c = 0; c < 3 * PER; c++) begin
			@(negedge CLK_IN);
			for (int p = 0; p < 3; p++) begin
				hi = HIGH_CMD_OUT[p];
				lo = LOW_CMD_OUT[p];
				if (hi && lo) n_both++;
				if (((hi && hw[p] == 0) || (lo && lw[p] == 0)) && gap[p] < `DEAD_CYC) n_dead++;
				if (hi && hw[p] == 0) begin
					if (rise[p] >= 0 && c - rise[p] != PER) n_per++;
					rise[p] = c;
					n_rise++;
				end
				if (!hi && hw[p] > 0 && hw[p] != exp_hi) n_hi++;
				if (!lo && lw[p] > 0 && lw[p] < `MIN_PULSE_CYC) n_lo++;
				hw[p] = hi ? hw[p] + 1 : 0;
				lw[p] = lo ? lw[p] + 1 : 0;
				gap[p] = (hi || lo) ? 0 : gap[p] + 1;
			end
		end
		chk_bit("pulses seen", 1'b1, n_rise >= 6);
		chk_bit("never both", 1'b1, n_both == 0);
		chk_bit("dead time", 1'b1, n_dead == 0);
		chk_bit("period", 1'b1, n_per == 0);
		chk_bit("high width", 1'b1, n_hi == 0);
		chk_bit("low width", 1'b1, n_lo == 0);
		chk_bit("running", 1'b1, RUNNING_OUT);
		stop_run();
		$display("Test pwm duty %0d done", d);
	endtask

	task automatic t_trip(int k);
		int n;
		DUTY_IN = {3{12'h064}};
		RUN_IN = 1;
		repeat (2 * PER) @(negedge CLK_IN);
		oc_sense = (k == 0);
		logic_uv = (k == 1);
		thermal = (k == 2);
		@(negedge CLK_IN);
		oc_sense = 0;
		wait_sig("sticky set", 0, 1'b1, 10, n);
		chk_bit("cmds dropped", 1'b0, |{HIGH_CMD_OUT, LOW_CMD_OUT});
		chk_bit("gates off", 1'b0, |{high_gate, low_gate});
		FAULT_CLEAR_IN = 1;
		@(negedge CLK_IN);
		FAULT_CLEAR_IN = 0;
		repeat (3) @(negedge CLK_IN);
		chk_bit("clear refused", 1'b1, FAULT_STICKY_OUT);
		logic_uv = 0;
		thermal = 0;
		wait_sig("line high", 1, 1'b1, 2000, n);
		chk_bit("sticky held", 1'b1, FAULT_STICKY_OUT);
		clear_sticky();
		wait_sig("resumed", 3, 1'b1, 2 * PER, n);
		stop_run();
		$display("Test trip %0d done", k);
	endtask

	task automatic t_shutdown();
		int n;
		SHUTDOWN_REQ_IN = 1;
		wait_sig("pull low", 2, 1'b0, 5, n);
		chk_bit("line low", 1'b0, line);
		chk_bit("drives zero", 1'b0, FAULT_LINE_OUT);
		SHUTDOWN_REQ_IN = 0;
		wait_sig("release", 2, 1'b1, 300, n);
		chk_bit("low span", 1'b1, n >= `SHDN_MIN_CYC - 5);
		SHUTDOWN_REQ_IN = 1;
		wait_sig("pull again", 2, 1'b0, 300, n);
		chk_bit("high span", 1'b1, n >= `SHDN_MIN_CYC - 5);
		SHUTDOWN_REQ_IN = 0;
		wait_sig("line back", 1, 1'b1, 300, n);
		chk_bit("self sticky", 1'b1, FAULT_STICKY_OUT);
		clear_sticky();
		$display("Test shutdown done");
	endtask

	task automatic complete_run();
		$display("Compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		#1000000;
		err_count++;
		$display("Error watchdog expected done seen timeout");
		complete_run();
	end

	initial begin
		repeat (2) @(negedge CLK_IN);
		RST_N_IN = 1;
		repeat (3) @(negedge CLK_IN);
		t_reset();
		t_pwm(100, 100);
		t_pwm(5, `MIN_PULSE_CYC);
		t_pwm(220, 220);
		for (int k = 0; k < 3; k++) t_trip(k);
		t_shutdown();
		complete_run();
	end
endmodule
